/* rtl/ahm_pkg.sv */
package ahm_pkg;

  localparam int LBA_W = 28;

  // task-file, status and read-only register indices on the plain register port
  localparam logic [3:0] ADDR_ERRFEAT = 4'h1;
  localparam logic [3:0] ADDR_SECCNT  = 4'h2;
  localparam logic [3:0] ADDR_SECNUM  = 4'h3;
  localparam logic [3:0] ADDR_CYLLO   = 4'h4;
  localparam logic [3:0] ADDR_CYLHI   = 4'h5;
  localparam logic [3:0] ADDR_DEVHEAD = 4'h6;
  localparam logic [3:0] ADDR_STATCMD = 4'h7;
  localparam logic [3:0] ADDR_MAX0    = 4'h8;
  localparam logic [3:0] ADDR_MAX1    = 4'h9;
  localparam logic [3:0] ADDR_MAX2    = 4'hA;
  localparam logic [3:0] ADDR_MAX3    = 4'hB;
  localparam logic [3:0] ADDR_MULT    = 4'hC;
  localparam logic [3:0] ADDR_FLAGS   = 4'hD;
  localparam logic [3:0] ADDR_IDW82L  = 4'hE;
  localparam logic [3:0] ADDR_IDW82H  = 4'hF;

  // command codes
  localparam logic [7:0] CMD_READ_NATIVE = 8'hF8;
  localparam logic [7:0] CMD_SET_MAX     = 8'hF9;
  localparam logic [7:0] CMD_SET_MULT    = 8'hC6;
  localparam logic [7:0] CMD_SLEEP_A     = 8'h99;
  localparam logic [7:0] CMD_SLEEP_B     = 8'hE6;
  localparam logic [7:0] CMD_STBY_A      = 8'h96;
  localparam logic [7:0] CMD_STBY_B      = 8'hE2;
  localparam logic [7:0] CMD_SMART       = 8'hB0;

  // set-max sub-functions in the features register
  localparam logic [7:0] HPA_FEAT_ADDR   = 8'h00;
  localparam logic [7:0] HPA_FEAT_PWD    = 8'h01;
  localparam logic [7:0] HPA_FEAT_LOCK   = 8'h02;
  localparam logic [7:0] HPA_FEAT_UNLOCK = 8'h03;
  localparam logic [7:0] HPA_FEAT_FREEZE = 8'h04;

  localparam logic [7:0] SMART_KEY_CYLHI = 8'hC2;
  localparam logic [7:0] SMART_DH_MASK   = 8'hE0;

  // bit positions
  localparam int DH_LBA_BIT     = 6;
  localparam int DH_DEV_BIT     = 4;
  localparam int SC_VOL_BIT     = 0;
  localparam int ST_BSY_BIT     = 7;
  localparam int ST_DRDY_BIT    = 6;
  localparam int ST_ERR_BIT     = 0;
  localparam int ER_ABRT_BIT    = 2;
  localparam int FLG_SLEEP      = 0;
  localparam int FLG_MULT_EN    = 1;
  localparam int FLG_LOCK       = 2;
  localparam int FLG_FROZEN     = 3;
  localparam int FLG_NATIVE_OK  = 4;
  localparam int FLG_NV_DONE    = 5;

  localparam logic [15:0] IDW82_RESET = 16'h0001;

  typedef enum logic {AHM_IDLE, AHM_EXEC} ahm_state_type;

endpackage : ahm_pkg

/* rtl/ahm_nv_store.sv */
`timescale 1ns/10ps
// holds the non-volatile capacity limit; untouched by the hardware reset pin
module ahm_nv_store #(
  parameter int              W         = 28,
  parameter logic [W-1:0]    RESET_VAL = '1
) (
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          wr_en_in,
  input  wire logic [W-1:0]  wr_data_in,
  output logic      [W-1:0]  rd_data_out
);

  typedef struct packed {
    logic [W-1:0] val;
  } ahm_nv_regs_type;

  ahm_nv_regs_type q;
  ahm_nv_regs_type d;

  always_comb begin
    d = q;
    if (wr_en_in) begin
      d.val = wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q.val <= RESET_VAL;
    end else begin
      q <= d;
    end
  end

  assign rd_data_out = q.val;

endmodule : ahm_nv_store

/* rtl/ahm_cmd_top.sv */
`timescale 1ns/10ps
// Functional notes
// - command F9h loads the reported maximum sector from the task file
// - volatility flag one: the new maximum survives hardware reset; power-on reset returns it to the native maximum
// - volatility flag zero: hardware reset returns to the last non-volatile maximum; power-on reset returns to the native maximum
// - features select sub-function: set, password, lock, unlock, freeze, rest reserved
// - a second non-volatile set-maximum after the same reset is aborted
// - command C6h sets busy and examines the requested sectors per block
// - a supported block count is stored and enables multiple transfers
// - an unsupported block count aborts and disables multiple transfers
// - a block count of zero leaves multiple transfers disabled
// - multiple transfers start disabled after power-on
// - sleep codes 99h/E6h: busy, low-power state, ready and interrupt at once
// - standby codes 96h/E2h behave the same way
// - any further command wakes the drive from the low-power state
// - identification word 82 bit 0 reports health monitoring support
module ahm_cmd_top
  import ahm_pkg::*;
#(
  parameter logic [LBA_W-1:0] NATIVE_MAX = 28'hFFFFFFF,
  parameter int               MAX_MULT   = 16,
  parameter logic             DEV_NUM    = 1'b0
) (
  input  wire logic              MCLK_IN,
  input  wire logic              RST_IN,
  input  wire logic              HW_RESET_IN,
  input  wire logic [3:0]        ADDR_IN,
  input  wire logic [7:0]        WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [7:0]        RDATA_OUT,
  output logic                   BSY_OUT,
  output logic                   INTRQ_OUT,
  output logic      [LBA_W-1:0]  MAX_LBA_OUT,
  output logic                   MULT_EN_OUT,
  output logic      [7:0]        MULT_COUNT_OUT,
  output logic                   SLEEP_OUT,
  output logic                   SMART_REQ_OUT,
  output logic      [7:0]        SMART_FEATURE_OUT,
  output logic      [15:0]       IDENT_W82_OUT
);

  typedef struct packed {
    ahm_state_type    state;
    logic [7:0]       feat;
    logic [7:0]       seccnt;
    logic [7:0]       secnum;
    logic [7:0]       cyllo;
    logic [7:0]       cylhi;
    logic [7:0]       devhead;
    logic [7:0]       cmd;
    logic [7:0]       rdata;
    logic [LBA_W-1:0] cur_max;
    logic [7:0]       mult_cnt;
    logic             mult_en;
    logic             sleep;
    logic             locked;
    logic             frozen;
    logic             native_ok;
    logic             nv_done;
    logic             err;
    logic             intrq;
    logic             smart_req;
    logic             hw1;
    logic             hw2;
    logic [15:0]      idw82;
  } ahm_regs_type;

  localparam ahm_regs_type REGS_RST = '{
    state:   AHM_IDLE,
    cur_max: NATIVE_MAX,
    idw82:   IDW82_RESET,
    default: '0
  };

  ahm_regs_type     q;
  ahm_regs_type     d;
  logic             nv_we;
  logic [LBA_W-1:0] nv_rd;
  logic [LBA_W-1:0] new_lba;
  logic             exec;
  logic             cmd_acc;
  logic             vol;
  logic             set_ok;
  logic             mult_good;

  function automatic logic [LBA_W-1:0] lba_of(input logic [7:0] dh, input logic [7:0] ch,
                                               input logic [7:0] cl, input logic [7:0] sn);
    lba_of = {dh[3:0], ch, cl, sn};
  endfunction : lba_of

  function automatic logic mult_ok(input logic [7:0] v);
    mult_ok = (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00) && (int'(v) <= MAX_MULT);
  endfunction : mult_ok

  assign exec      = (q.state == AHM_EXEC);
  assign new_lba   = lba_of(q.devhead, q.cylhi, q.cyllo, q.secnum);
  assign vol       = q.seccnt[SC_VOL_BIT];
  assign mult_good = mult_ok(q.seccnt);
  // device-select bit of the stored drive/head decides who takes the command
  assign cmd_acc   = WR_IN && (ADDR_IN == ADDR_STATCMD) && !exec &&
                     (q.devhead[DH_DEV_BIT] == DEV_NUM);
  // the limit may only move right after a read of the native maximum
  assign set_ok    = q.native_ok && !q.locked && !q.frozen && (new_lba <= NATIVE_MAX) &&
                     !(vol && q.nv_done);

  ahm_nv_store #(
    .W         (LBA_W),
    .RESET_VAL (NATIVE_MAX)
  ) u_nv (
    .clk_in      (MCLK_IN),
    .rst_in      (RST_IN),
    .wr_en_in    (nv_we),
    .wr_data_in  (new_lba),
    .rd_data_out (nv_rd)
  );

  always_comb begin
    d           = q;
    nv_we       = 1'b0;
    d.hw1       = HW_RESET_IN;
    d.hw2       = q.hw1;
    d.rdata     = 8'h00;
    d.smart_req = 1'b0;
    if (RD_IN) begin
      unique case (ADDR_IN)
        ADDR_ERRFEAT: d.rdata = {5'h00, q.err, 2'h0};
        ADDR_SECCNT:  d.rdata = q.seccnt;
        ADDR_SECNUM:  d.rdata = q.secnum;
        ADDR_CYLLO:   d.rdata = q.cyllo;
        ADDR_CYLHI:   d.rdata = q.cylhi;
        ADDR_DEVHEAD: d.rdata = q.devhead;
        ADDR_STATCMD: d.rdata = {exec, 1'b1, 5'h00, q.err};
        ADDR_MAX0:    d.rdata = q.cur_max[7:0];
        ADDR_MAX1:    d.rdata = q.cur_max[15:8];
        ADDR_MAX2:    d.rdata = q.cur_max[23:16];
        ADDR_MAX3:    d.rdata = {4'h0, q.cur_max[27:24]};
        ADDR_MULT:    d.rdata = q.mult_cnt;
        ADDR_FLAGS:   d.rdata = {2'h0, q.nv_done, q.native_ok, q.frozen, q.locked,
                                 q.mult_en, q.sleep};
        ADDR_IDW82L:  d.rdata = q.idw82[7:0];
        ADDR_IDW82H:  d.rdata = q.idw82[15:8];
        default:      d.rdata = 8'h00;
      endcase
      if (ADDR_IN == ADDR_STATCMD) begin
        d.intrq = 1'b0;
      end
    end
    if (WR_IN && !exec) begin
      unique case (ADDR_IN)
        ADDR_ERRFEAT: d.feat    = WDATA_IN;
        ADDR_SECCNT:  d.seccnt  = WDATA_IN;
        ADDR_SECNUM:  d.secnum  = WDATA_IN;
        ADDR_CYLLO:   d.cyllo   = WDATA_IN;
        ADDR_CYLHI:   d.cylhi   = WDATA_IN;
        ADDR_DEVHEAD: d.devhead = WDATA_IN;
        default:      d.cmd     = q.cmd;
      endcase
    end
    if (cmd_acc) begin
      d.cmd   = WDATA_IN;
      d.sleep = 1'b0;
      d.intrq = 1'b0;
      d.state = AHM_EXEC;
    end
    if (exec) begin
      d.state     = AHM_IDLE;
      d.intrq     = 1'b1;
      d.err       = 1'b0;
      d.native_ok = 1'b0;
      unique case (q.cmd)
        CMD_READ_NATIVE: begin
          d.secnum    = NATIVE_MAX[7:0];
          d.cyllo     = NATIVE_MAX[15:8];
          d.cylhi     = NATIVE_MAX[23:16];
          d.devhead   = {q.devhead[7:4], NATIVE_MAX[27:24]};
          d.native_ok = 1'b1;
        end
        CMD_SET_MAX: begin
          unique case (q.feat)
            HPA_FEAT_ADDR: begin
              if (set_ok) begin
                d.cur_max = new_lba;
                if (vol) begin
                  nv_we     = 1'b1;
                  d.nv_done = 1'b1;
                end
              end else begin
                d.err = 1'b1;
              end
            end
            HPA_FEAT_PWD:    d.err = q.frozen;
            HPA_FEAT_LOCK: begin
              d.err    = q.frozen;
              d.locked = q.locked | !q.frozen;
            end
            HPA_FEAT_UNLOCK: begin
              d.err    = q.frozen;
              d.locked = q.locked & q.frozen;
            end
            HPA_FEAT_FREEZE: d.frozen = 1'b1;
            default:         d.err = 1'b1;
          endcase
        end
        CMD_SET_MULT: begin
          if (q.seccnt == 8'h00) begin
            d.mult_en = 1'b0;
          end else if (mult_good) begin
            d.mult_en  = 1'b1;
            d.mult_cnt = q.seccnt;
          end else begin
            d.mult_en = 1'b0;
            d.err     = 1'b1;
          end
        end
        CMD_SLEEP_A, CMD_SLEEP_B: d.sleep = 1'b1;
        CMD_STBY_A, CMD_STBY_B:   d.sleep = 1'b1;
        CMD_SMART: begin
          if ((q.cylhi == SMART_KEY_CYLHI) &&
              ((q.devhead & SMART_DH_MASK) == SMART_DH_MASK)) begin
            d.smart_req = 1'b1;
          end else begin
            d.err = 1'b1;
          end
        end
        default: d.err = 1'b1;
      endcase
    end
    // hardware reset pin: volatile limit falls back to the stored one
    if (q.hw2) begin
      d.cur_max   = nv_rd;
      d.nv_done   = 1'b0;
      d.native_ok = 1'b0;
      d.locked    = 1'b0;
      d.frozen    = 1'b0;
      d.state     = AHM_IDLE;
      d.smart_req = 1'b0;
      nv_we       = 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  assign RDATA_OUT         = q.rdata;
  assign BSY_OUT           = exec;
  assign INTRQ_OUT         = q.intrq;
  assign MAX_LBA_OUT       = q.cur_max;
  assign MULT_EN_OUT       = q.mult_en;
  assign MULT_COUNT_OUT    = q.mult_cnt;
  assign SLEEP_OUT         = q.sleep;
  assign SMART_REQ_OUT     = q.smart_req;
  assign SMART_FEATURE_OUT = q.feat;
  assign IDENT_W82_OUT     = q.idw82;

  property p_setmax_update;
    @(posedge MCLK_IN) disable iff (RST_IN)
    exec && (q.cmd == CMD_SET_MAX) && (q.feat == HPA_FEAT_ADDR) && set_ok && !q.hw2
      |=> (MAX_LBA_OUT == $past(new_lba)) && !q.err;
  endproperty
  a_setmax_update: assert property (p_setmax_update) else $error("set max not loaded");

  property p_nv_keep;
    @(posedge MCLK_IN) disable iff (RST_IN)
    nv_we |-> ##1 (nv_rd == $past(new_lba)) ##1 (nv_rd == $past(new_lba, 2));
  endproperty
  a_nv_keep: assert property (p_nv_keep) else $error("non-volatile limit not stored");

  property p_hw_revert;
    @(posedge MCLK_IN) disable iff (RST_IN)
    q.hw2 |=> (MAX_LBA_OUT == $past(nv_rd)) && !q.nv_done && !BSY_OUT;
  endproperty
  a_hw_revert: assert property (p_hw_revert) else $error("no revert on hw reset");

  property p_lock_feat;
    @(posedge MCLK_IN) disable iff (RST_IN)
    exec && !q.hw2 && (q.cmd == CMD_SET_MAX) && (q.feat == HPA_FEAT_LOCK) && !q.frozen
      |=> q.locked && !q.err;
  endproperty
  a_lock_feat: assert property (p_lock_feat) else $error("lock sub-function failed");

  property p_nv_second;
    @(posedge MCLK_IN) disable iff (RST_IN)
    exec && !q.hw2 && (q.cmd == CMD_SET_MAX) && (q.feat == HPA_FEAT_ADDR) && vol && q.nv_done
      |=> q.err && $stable(MAX_LBA_OUT);
  endproperty
  a_nv_second: assert property (p_nv_second) else $error("second nv set not aborted");

  property p_busy_complete;
    @(posedge MCLK_IN) disable iff (RST_IN)
    cmd_acc && !q.hw2 |=> BSY_OUT ##1 (!BSY_OUT && INTRQ_OUT);
  endproperty
  a_busy_complete: assert property (p_busy_complete) else $error("busy/complete wrong");

  property p_mult_good;
    @(posedge MCLK_IN) disable iff (RST_IN)
    exec && !q.hw2 && (q.cmd == CMD_SET_MULT) && mult_good
      |=> MULT_EN_OUT && (MULT_COUNT_OUT == $past(q.seccnt)) && !q.err;
  endproperty
  a_mult_good: assert property (p_mult_good) else $error("block count not taken");

  property p_mult_bad;
    @(posedge MCLK_IN) disable iff (RST_IN)
    exec && !q.hw2 && (q.cmd == CMD_SET_MULT) && (q.seccnt != 8'h00) && !mult_good
      |=> !MULT_EN_OUT && q.err;
  endproperty
  a_mult_bad: assert property (p_mult_bad) else $error("bad block count not aborted");

  property p_mult_zero;
    @(posedge MCLK_IN) disable iff (RST_IN)
    exec && !q.hw2 && (q.cmd == CMD_SET_MULT) && (q.seccnt == 8'h00)
      |=> !MULT_EN_OUT && !q.err;
  endproperty
  a_mult_zero: assert property (p_mult_zero) else $error("zero count enabled multiple");

  property p_mult_por;
    @(posedge MCLK_IN) $fell(RST_IN) |-> !MULT_EN_OUT && !BSY_OUT && !SLEEP_OUT;
  endproperty
  a_mult_por: assert property (p_mult_por) else $error("multiple enabled after reset");

  property p_sleep;
    @(posedge MCLK_IN) disable iff (RST_IN)
    exec && !q.hw2 && ((q.cmd == CMD_SLEEP_A) || (q.cmd == CMD_SLEEP_B))
      |=> SLEEP_OUT && INTRQ_OUT && !BSY_OUT;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");

  property p_standby;
    @(posedge MCLK_IN) disable iff (RST_IN)
    exec && !q.hw2 && ((q.cmd == CMD_STBY_A) || (q.cmd == CMD_STBY_B))
      |=> SLEEP_OUT && INTRQ_OUT && !BSY_OUT;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");

  property p_wake;
    @(posedge MCLK_IN) disable iff (RST_IN)
    SLEEP_OUT && cmd_acc |=> !SLEEP_OUT && BSY_OUT;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on command");

  property p_ident;
    @(posedge MCLK_IN) disable iff (RST_IN)
    IDENT_W82_OUT == IDW82_RESET;
  endproperty
  a_ident: assert property (p_ident) else $error("ident word 82 wrong");

  property p_no_prior;
    @(posedge MCLK_IN) disable iff (RST_IN)
    exec && !q.hw2 && (q.cmd == CMD_SET_MAX) && (q.feat == HPA_FEAT_ADDR) && !q.native_ok
      |=> q.err && $stable(MAX_LBA_OUT);
  endproperty
  a_no_prior: assert property (p_no_prior) else $error("set max without F8h taken");

  c_setmax:  cover property (@(posedge MCLK_IN) disable iff (RST_IN)
                             exec && (q.cmd == CMD_SET_MAX) && set_ok);
  c_mult:    cover property (@(posedge MCLK_IN) disable iff (RST_IN)
                             exec && (q.cmd == CMD_SET_MULT) && mult_good);
  c_wake:    cover property (@(posedge MCLK_IN) disable iff (RST_IN) SLEEP_OUT && cmd_acc);
  c_hwreset: cover property (@(posedge MCLK_IN) disable iff (RST_IN) q.hw2 && q.nv_done);

endmodule : ahm_cmd_top

/* test/ahm_host_model.sv */
`timescale 1ns/10ps
// host side of the task-file port: plain strobe bus, one request at a time
module ahm_host_model
  import ahm_pkg::*;
(
  input  wire logic        clk_in,
  output logic      [3:0]  addr_out,
  output logic      [7:0]  wdata_out,
  output logic             wr_out,
  output logic             rd_out,
  input  wire logic [7:0]  rdata_in
);
  initial begin
    addr_out  = 4'h0;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
  endtask : wr

  // read data stand in the cycle after the strobe; taken at the edge ending it
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    @(posedge clk_in);
    d = rdata_in;
  endtask : rd

  // loads features, sector count and a 28-bit address split over four registers
  task automatic tf(input logic [7:0] feat, input logic [7:0] sc, input logic [27:0] lba);
    wr(ADDR_ERRFEAT, feat);
    wr(ADDR_SECCNT, sc);
    wr(ADDR_SECNUM, lba[7:0]);
    wr(ADDR_CYLLO, lba[15:8]);
    wr(ADDR_CYLHI, lba[23:16]);
    wr(ADDR_DEVHEAD, {3'b111, 1'b0, lba[27:24]});
  endtask : tf
endmodule : ahm_host_model

/* test/tb.sv */
`timescale 1ns/10ps
module tb;
  import ahm_pkg::*;
  localparam logic [LBA_W-1:0] NATIVE = 28'h0ABCDEF;
  localparam logic [27:0]      LBA_A  = 28'h0012345;
  localparam logic [27:0]      LBA_B  = 28'h0054321;
  localparam logic [27:0]      LBA_C  = 28'h0000777;
  localparam logic [39:0]      FEATS  = 40'h0102030504;
  localparam logic [4:0]       FERR   = 5'b00010;
  localparam logic [39:0]      MCNT   = 40'h0004031020;
  localparam logic [4:0]       MEN    = 5'b01010;
  localparam logic [4:0]       MERR   = 5'b00101;
  localparam logic [31:0]      NAPS   = 32'h99E696E2;

  logic             clk    = 1'b0;
  logic             rst    = 1'b1;
  logic             hw_rst = 1'b0;
  logic [3:0]       addr;
  logic [7:0]       wdata;
  logic             wr;
  logic             rd;
  logic [7:0]       rdata;
  logic             bsy;
  logic             intrq;
  logic [LBA_W-1:0] max_lba;
  logic             mult_en;
  logic [7:0]       mult_cnt;
  logic             sleep;
  logic             smart_req;
  logic [7:0]       smart_feat;
  logic [15:0]      w82;
  int               num_errors = 0;
  int               cmp_count  = 0;

  always #4 clk = ~clk;

  ahm_host_model host (
    .clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd),
    .rdata_in(rdata)
  );

  ahm_cmd_top #(.NATIVE_MAX(NATIVE), .MAX_MULT(16), .DEV_NUM(1'b0)) dut (
    .MCLK_IN(clk), .RST_IN(rst), .HW_RESET_IN(hw_rst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .BSY_OUT(bsy),
    .INTRQ_OUT(intrq), .MAX_LBA_OUT(max_lba), .MULT_EN_OUT(mult_en),
    .MULT_COUNT_OUT(mult_cnt), .SLEEP_OUT(sleep), .SMART_REQ_OUT(smart_req),
    .SMART_FEATURE_OUT(smart_feat), .IDENT_W82_OUT(w82)
  );

  task automatic chk(input logic [27:0] seen, input logic [27:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // issues one command and judges busy, interrupt, smart pulse and error bits
  task automatic cmd(input logic [7:0] code, input logic err);
    logic [7:0] st;
    host.wr(ADDR_STATCMD, code);
    #1 chk(bsy, 1'b1, "busy");
    @(posedge clk);
    #1 chk(bsy, 1'b0, "busy clear");
    chk(intrq, 1'b1, "intrq");
    chk(smart_req, (code == CMD_SMART) && !err, "smart req");
    host.rd(ADDR_STATCMD, st);
    chk(st[ST_ERR_BIT], err, "status err");
    chk(st[ST_DRDY_BIT], 1'b1, "drive ready");
    chk(st[ST_BSY_BIT], 1'b0, "status busy");
    chk(intrq, 1'b0, "intrq cleared by status read");
    host.rd(ADDR_ERRFEAT, st);
    chk(st[ER_ABRT_BIT], err, "abort bit");
  endtask : cmd

  task automatic hw_reset;
    hw_rst <= 1'b1;
    repeat (3) @(posedge clk);
    hw_rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : hw_reset

  task automatic t_reset;
    logic [7:0] d;
    #1 chk(mult_en, 1'b0, "mult en at reset");
    chk(max_lba, NATIVE, "max at reset");
    chk(w82[0], 1'b1, "word82 bit0");
    host.rd(4'h0, d);
    chk(d, 8'h00, "unmapped read");
    host.rd(ADDR_IDW82L, d);
    chk(d[0], 1'b1, "word82 low read");
  endtask : t_reset

  task automatic t_hpa;
    logic [7:0] d;
    host.tf(HPA_FEAT_ADDR, 8'h01, LBA_A);
    cmd(CMD_SET_MAX, 1'b1);
    chk(max_lba, NATIVE, "max without native read");
    cmd(CMD_READ_NATIVE, 1'b0);
    host.rd(ADDR_SECNUM, d);
    chk(d, NATIVE[7:0], "native low byte");
    host.tf(HPA_FEAT_ADDR, 8'h01, LBA_A);
    cmd(CMD_SET_MAX, 1'b0);
    chk(max_lba, LBA_A, "max set");
    host.rd(ADDR_MAX3, d);
    chk(d[3:0], LBA_A[27:24], "max top nibble");
    cmd(CMD_READ_NATIVE, 1'b0);
    host.tf(HPA_FEAT_ADDR, 8'h01, LBA_B);
    cmd(CMD_SET_MAX, 1'b1);
    chk(max_lba, LBA_A, "second nv set");
    hw_reset();
    chk(max_lba, LBA_A, "nv kept over reset");
    cmd(CMD_READ_NATIVE, 1'b0);
    host.tf(HPA_FEAT_ADDR, 8'h00, LBA_C);
    cmd(CMD_SET_MAX, 1'b0);
    chk(max_lba, LBA_C, "volatile set");
    hw_reset();
    chk(max_lba, LBA_A, "volatile reverts");
  endtask : t_hpa

  task automatic t_feat;
    for (int i = 0; i < 5; i++) begin
      cmd(CMD_READ_NATIVE, 1'b0);
      host.tf(FEATS[8*(4-i) +: 8], 8'h00, LBA_A);
      cmd(CMD_SET_MAX, FERR[4-i]);
    end
    cmd(CMD_READ_NATIVE, 1'b0);
    host.tf(HPA_FEAT_ADDR, 8'h00, LBA_C);
    cmd(CMD_SET_MAX, 1'b1);
    chk(max_lba, LBA_A, "max while frozen");
    hw_reset();
  endtask : t_feat

  task automatic t_mult;
    for (int i = 0; i < 5; i++) begin
      host.tf(8'h00, MCNT[8*(4-i) +: 8], LBA_A);
      cmd(CMD_SET_MULT, MERR[4-i]);
      chk(mult_en, MEN[4-i], "mult enable");
      if (MEN[4-i])
        chk(mult_cnt, MCNT[8*(4-i) +: 8], "mult count");
    end
  endtask : t_mult

  task automatic t_sleep;
    for (int i = 0; i < 4; i++) begin
      cmd(NAPS[8*(3-i) +: 8], 1'b0);
      chk(sleep, 1'b1, "low power");
    end
    host.tf(8'h00, 8'h00, LBA_A);
    cmd(CMD_SET_MULT, 1'b0);
    chk(sleep, 1'b0, "woken");
  endtask : t_sleep

  task automatic t_smart_dev;
    host.tf(8'hD8, 8'h00, 28'h0C20000);
    cmd(CMD_SMART, 1'b0);
    chk(smart_feat, 8'hD8, "smart feature");
    host.tf(8'hD8, 8'h00, 28'h0000000);
    cmd(CMD_SMART, 1'b1);
    host.wr(ADDR_DEVHEAD, 8'hF0);
    host.wr(ADDR_STATCMD, CMD_SLEEP_A);
    #1 chk(bsy, 1'b0, "other device busy");
    @(posedge clk);
    #1 chk(sleep, 1'b0, "other device sleep");
  endtask : t_smart_dev

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_hpa();
    t_feat();
    t_mult();
    t_sleep();
    t_smart_dev();
    stop_test();
  end

  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule : tb
